// ===== core/dual_timer_counter_control.sv
// two timer/counters with flags, run control and external interrupt detect
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_control (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // byte register access
  input wire timer_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // bit access
  input wire timer_pkg::bit_req_s bit_req,
  output logic bit_rdata,
  // vectoring acknowledges
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic irq0_vector_ack,
  input wire logic irq1_vector_ack,
  // pins
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic count0_pin,
  input wire logic count1_pin,
  // flags
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic ext_irq0_detect_flag,
  output logic ext_irq1_detect_flag
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  logic tf1_reg;
  logic tr1_reg;
  logic tf0_reg;
  logic tr0_reg;
  logic it1_reg;
  logic it0_reg;
  logic [7:0] timer_mode_select_reg;
  logic [1:0] clk_sel_reg;
  logic [7:0] t0_low_reg;
  logic [7:0] t0_high_reg;
  logic [7:0] t1_low_reg;
  logic [7:0] t1_high_reg;
  logic count0_prev_reg;
  logic count1_prev_reg;
  logic [7:0] sfr_rdata_reg;
  logic bit_rdata_reg;

  logic [7:0] ctrl_mask;
  logic [7:0] ctrl_data;
  logic [7:0] ctrl_read;
  logic [7:0] rd_next;
  timer_pkg::timer_mode_select_half_s t0_cfg;
  timer_pkg::timer_mode_select_half_s t1_cfg;
  logic tick0;
  logic tick1;
  logic count0_fall;
  logic count1_fall;
  logic t0_split;
  logic t1_stop;
  logic t0_inc;
  logic t0h_inc;
  logic t1_inc;
  timer_pkg::count_s t0_step;
  timer_pkg::count_s t0h_step;
  timer_pkg::count_s t1_step;
  logic tf0_set;
  logic tf1_set;
  logic wr_t0l;
  logic wr_t0h;
  logic wr_t1l;
  logic wr_t1h;

  // reset release through two flops; assert stays asynchronous
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  function automatic logic byte_wr(timer_pkg::sfr_req_s req, logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  assign wr_t0l = byte_wr(sfr_req, timer_pkg::ADDR_T0L);
  assign wr_t0h = byte_wr(sfr_req, timer_pkg::ADDR_T0H);
  assign wr_t1l = byte_wr(sfr_req, timer_pkg::ADDR_T1L);
  assign wr_t1h = byte_wr(sfr_req, timer_pkg::ADDR_T1H);

  // byte write or single-bit write into the control register
  always_comb begin
    ctrl_mask = 8'h00;
    ctrl_data = sfr_req.wdata;
    if (byte_wr(sfr_req, timer_pkg::ADDR_CTRL)) begin
      ctrl_mask = 8'hFF;
    end else if (bit_req.wr && bit_req.addr[7:3] == timer_pkg::ADDR_CTRL[7:3]) begin
      ctrl_mask = 8'h01 << bit_req.addr[2:0];
      ctrl_data = {8{bit_req.val}};
    end
  end

  assign t0_cfg = timer_pkg::timer_mode_select_half_s'(timer_mode_select_reg[3:0]);
  assign t1_cfg = timer_pkg::timer_mode_select_half_s'(timer_mode_select_reg[7:4]);
  assign t0_split = (t0_cfg.mode == timer_pkg::MODE_SPLIT);
  assign t1_stop = (t1_cfg.mode == timer_pkg::MODE_SPLIT);

  tick_divider u_tick0 (
    .clk(sys_clk),
    .rst_n(rst_n),
    .fast_sel(clk_sel_reg[0]),
    .tick(tick0)
  );

  tick_divider u_tick1 (
    .clk(sys_clk),
    .rst_n(rst_n),
    .fast_sel(clk_sel_reg[1]),
    .tick(tick1)
  );

  irq_detect u_irq0 (
    .clk(sys_clk),
    .rst_n(rst_n),
    .pin(ext_irq0_pin),
    .edge_mode(it0_reg),
    .vector_ack(irq0_vector_ack),
    .sw_wr(ctrl_mask[timer_pkg::BIT_IE0]),
    .sw_val(ctrl_data[timer_pkg::BIT_IE0]),
    .flag(ext_irq0_detect_flag)
  );

  irq_detect u_irq1 (
    .clk(sys_clk),
    .rst_n(rst_n),
    .pin(ext_irq1_pin),
    .edge_mode(it1_reg),
    .vector_ack(irq1_vector_ack),
    .sw_wr(ctrl_mask[timer_pkg::BIT_IE1]),
    .sw_val(ctrl_data[timer_pkg::BIT_IE1]),
    .flag(ext_irq1_detect_flag)
  );

  // count pins: edge found from one flop of history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count0_prev_reg <= 1'b1;
      count1_prev_reg <= 1'b1;
    end else begin
      count0_prev_reg <= count0_pin;
      count1_prev_reg <= count1_pin;
    end
  end
  assign count0_fall = count0_prev_reg & ~count0_pin;
  assign count1_fall = count1_prev_reg & ~count1_pin;

  // count enables
  assign t0_inc = tr0_reg & (~t0_cfg.gate | ext_irq0_pin)
    & (t0_cfg.counter_sel ? count0_fall : tick0);
  assign t0h_inc = tr1_reg & tick0;
  assign t1_inc = tr1_reg & (~t1_cfg.gate | ext_irq1_pin) & ~t1_stop
    & (t1_cfg.counter_sel ? count1_fall : tick1);

  assign t0_step = timer_pkg::count_step(t0_cfg.mode, t0_low_reg, t0_high_reg, t0_inc);
  assign t0h_step = timer_pkg::count_step(timer_pkg::MODE_SPLIT, t0_high_reg,
                                          timer_pkg::RESET_BYTE, t0h_inc);
  assign t1_step = timer_pkg::count_step(t1_cfg.mode, t1_low_reg, t1_high_reg, t1_inc);

  assign tf0_set = t0_step.ovf;
  // while timer 0 is split, timer 1 overflow has no flag of its own
  assign tf1_set = t0_split ? t0h_step.ovf : t1_step.ovf;

  // timer 0 count; a write wins over a count in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_low_reg <= timer_pkg::RESET_BYTE;
      t0_high_reg <= timer_pkg::RESET_BYTE;
    end else begin
      t0_low_reg <= wr_t0l ? sfr_req.wdata : t0_step.low;
      if (wr_t0h) begin
        t0_high_reg <= sfr_req.wdata;
      end else if (t0_split) begin
        t0_high_reg <= t0h_step.low;
      end else begin
        t0_high_reg <= t0_step.high;
      end
    end
  end

  // timer 1 count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t1_low_reg <= timer_pkg::RESET_BYTE;
      t1_high_reg <= timer_pkg::RESET_BYTE;
    end else begin
      t1_low_reg <= wr_t1l ? sfr_req.wdata : t1_step.low;
      t1_high_reg <= wr_t1h ? sfr_req.wdata : t1_step.high;
    end
  end

  // overflow flags: set beats acknowledge beats software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf0_reg <= 1'b0;
    end else if (tf0_set) begin
      tf0_reg <= 1'b1;
    end else if (timer0_vector_ack) begin
      tf0_reg <= 1'b0;
    end else if (ctrl_mask[timer_pkg::BIT_TF0]) begin
      tf0_reg <= ctrl_data[timer_pkg::BIT_TF0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf1_reg <= 1'b0;
    end else if (tf1_set) begin
      tf1_reg <= 1'b1;
    end else if (timer1_vector_ack) begin
      tf1_reg <= 1'b0;
    end else if (ctrl_mask[timer_pkg::BIT_TF1]) begin
      tf1_reg <= ctrl_data[timer_pkg::BIT_TF1];
    end
  end

  // software-only control bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tr0_reg <= 1'b0;
      tr1_reg <= 1'b0;
      it0_reg <= 1'b0;
      it1_reg <= 1'b0;
    end else begin
      if (ctrl_mask[timer_pkg::BIT_TR0]) tr0_reg <= ctrl_data[timer_pkg::BIT_TR0];
      if (ctrl_mask[timer_pkg::BIT_TR1]) tr1_reg <= ctrl_data[timer_pkg::BIT_TR1];
      if (ctrl_mask[timer_pkg::BIT_IT0]) it0_reg <= ctrl_data[timer_pkg::BIT_IT0];
      if (ctrl_mask[timer_pkg::BIT_IT1]) it1_reg <= ctrl_data[timer_pkg::BIT_IT1];
    end
  end

  // mode and clock select, byte access only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_select_reg <= timer_pkg::RESET_BYTE;
      clk_sel_reg <= 2'b00;
    end else begin
      if (byte_wr(sfr_req, timer_pkg::ADDR_MODE)) timer_mode_select_reg <= sfr_req.wdata;
      if (byte_wr(sfr_req, timer_pkg::ADDR_CLK)) begin
        clk_sel_reg <= sfr_req.wdata[timer_pkg::CLK_T0M_BIT +: 2];
      end
    end
  end

  // read paths, one clock of latency
  assign ctrl_read = {tf1_reg, tr1_reg, tf0_reg, tr0_reg,
                      ext_irq1_detect_flag, it1_reg, ext_irq0_detect_flag, it0_reg};

  always_comb begin
    case (sfr_req.addr)
      timer_pkg::ADDR_CTRL: rd_next = ctrl_read;
      timer_pkg::ADDR_MODE: rd_next = timer_mode_select_reg;
      timer_pkg::ADDR_T0L: rd_next = t0_low_reg;
      timer_pkg::ADDR_T1L: rd_next = t1_low_reg;
      timer_pkg::ADDR_T0H: rd_next = t0_high_reg;
      timer_pkg::ADDR_T1H: rd_next = t1_high_reg;
      timer_pkg::ADDR_CLK: rd_next = ~timer_pkg::CLK_IMPL_MASK
        | (8'(clk_sel_reg) << timer_pkg::CLK_T0M_BIT);
      default: rd_next = timer_pkg::UNIMP_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_reg <= timer_pkg::UNIMP_BYTE;
      bit_rdata_reg <= 1'b1;
    end else begin
      sfr_rdata_reg <= rd_next;
      // bits outside this register are not ours and read high
      bit_rdata_reg <= (bit_req.addr[7:3] == timer_pkg::ADDR_CTRL[7:3])
        ? ctrl_read[bit_req.addr[2:0]] : 1'b1;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign bit_rdata = bit_rdata_reg;
  assign timer0_overflow_flag = tf0_reg;
  assign timer1_overflow_flag = tf1_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_tf0_set: assert property (t0_inc && !wr_t0l && !wr_t0h
    && t0_cfg.mode == timer_pkg::MODE_FULL16
    && {t0_high_reg, t0_low_reg} == {2{timer_pkg::ONES_BYTE}}
    |=> timer0_overflow_flag && {t0_high_reg, t0_low_reg} == {2{timer_pkg::RESET_BYTE}})
    else $error("timer 0 overflow lost");

  a_tf1_ack: assert property (timer1_vector_ack && !tf1_set |=> !timer1_overflow_flag)
    else $error("timer 1 flag not cleared on vector");

  a_run_off: assert property (!tr0_reg && !wr_t0l |=> $stable(t0_low_reg))
    else $error("timer 0 counted while stopped");

  a_gate_hold: assert property (t0_cfg.gate && !ext_irq0_pin && !wr_t0l
    |=> $stable(t0_low_reg))
    else $error("gated timer 0 counted with pin low");

  a_edge_count: assert property (t0_cfg.counter_sel && !count0_fall && !wr_t0l
    |=> $stable(t0_low_reg))
    else $error("counter advanced without pin edge");

  a_t1_hold: assert property (t1_stop && !wr_t1l && !wr_t1h
    |=> $stable({t1_low_reg, t1_high_reg}))
    else $error("timer 1 moved in mode 3");

  sequence reload_wrap;
    t0_cfg.mode == timer_pkg::MODE_RELOAD && t0_inc
      && t0_low_reg == timer_pkg::ONES_BYTE && !wr_t0l && !wr_t0h;
  endsequence

  a_reload_load: assert property (reload_wrap
    |=> t0_low_reg == $past(t0_high_reg) && $stable(t0_high_reg) && timer0_overflow_flag)
    else $error("reload did not load high byte");

  a_unimp_read: assert property (sfr_req.addr == 8'h8F |=> sfr_rdata == 8'hFF)
    else $error("unimplemented address not read as ones");

endmodule
`default_nettype wire

// ===== core/timer_pkg.sv
// shared constants, types and the count step for the dual timer block
package timer_pkg;

  // register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0L = 8'h8A;
  localparam logic [7:0] ADDR_T1L = 8'h8B;
  localparam logic [7:0] ADDR_T0H = 8'h8C;
  localparam logic [7:0] ADDR_T1H = 8'h8D;
  localparam logic [7:0] ADDR_CLK = 8'h8E;

  // control register bit positions
  localparam int unsigned BIT_TF1 = 7;
  localparam int unsigned BIT_TR1 = 6;
  localparam int unsigned BIT_TF0 = 5;
  localparam int unsigned BIT_TR0 = 4;
  localparam int unsigned BIT_IE1 = 3;
  localparam int unsigned BIT_IT1 = 2;
  localparam int unsigned BIT_IE0 = 1;
  localparam int unsigned BIT_IT0 = 0;

  // clock control: prescale select bits, the rest unimplemented
  localparam int unsigned CLK_T0M_BIT = 4;
  localparam logic [7:0] CLK_IMPL_MASK = 8'h30;

  // reset values and read of unimplemented space
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNIMP_BYTE = 8'hFF;
  localparam logic [7:0] ONES_BYTE = 8'hFF;

  // internal clock division
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_SLOW = 4'hC;

  // low-byte prescaler width in the prescaled mode
  localparam int unsigned PRE_BITS = 5;

  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_FULL16,
    MODE_RELOAD,
    MODE_SPLIT
  } timer_mode_e;

  typedef struct packed {
    logic gate;
    logic counter_sel;
    timer_mode_e mode;
  } timer_mode_select_half_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic val;
  } bit_req_s;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } count_s;

  // one count step of a timer in the given mode
  function automatic count_s count_step(timer_mode_e mode, logic [7:0] low,
                                        logic [7:0] high, logic inc);
    count_s r;
    logic [PRE_BITS+7:0] p13;
    logic [15:0] p16;
    r.low = low;
    r.high = high;
    r.ovf = 1'b0;
    p13 = {high, low[PRE_BITS-1:0]} + {{(PRE_BITS+7){1'b0}}, 1'b1};
    p16 = {high, low} + 16'h0001;
    if (inc) begin
      case (mode)
        MODE_PRESCALED: begin
          // upper low-byte bits are left alone
          r.high = p13[PRE_BITS+7:PRE_BITS];
          r.low = {low[7:PRE_BITS], p13[PRE_BITS-1:0]};
          r.ovf = &{high, low[PRE_BITS-1:0]};
        end
        MODE_FULL16: begin
          r.high = p16[15:8];
          r.low = p16[7:0];
          r.ovf = &{high, low};
        end
        MODE_RELOAD: begin
          r.low = (low == ONES_BYTE) ? high : p16[7:0];
          r.ovf = (low == ONES_BYTE);
        end
        default: begin
          r.low = p16[7:0];
          r.ovf = (low == ONES_BYTE);
        end
      endcase
    end
    return r;
  endfunction

endpackage

// ===== core/tick_divider.sv
// internal count tick, one every 4 or 12 system clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic fast_sel,
  // tick
  output logic tick
);
  logic [3:0] cnt_reg;
  logic [3:0] last;
  logic tick_reg;

  assign last = (fast_sel ? timer_pkg::DIV_FAST : timer_pkg::DIV_SLOW) - 4'h1;
  assign tick = tick_reg;

  // >= so a switch from slow to fast cannot run past the end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> (!tick)[*3])
    else $error("ticks closer than four clocks");

endmodule
`default_nettype wire

// ===== core/irq_detect.sv
// external interrupt detect flag for one pin
`timescale 1ns/1ps
`default_nettype none
module irq_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and type
  input wire logic pin,
  input wire logic edge_mode,
  // clears and writes
  input wire logic vector_ack,
  input wire logic sw_wr,
  input wire logic sw_val,
  // flag
  output logic flag
);
  logic pin_prev_reg;
  logic flag_reg;
  logic fall;

  assign fall = pin_prev_reg & ~pin;
  assign flag = flag_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_reg <= 1'b1;
    end else begin
      pin_prev_reg <= pin;
    end
  end

  // edge set beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (!edge_mode) begin
      flag_reg <= ~pin;
    end else if (fall) begin
      flag_reg <= 1'b1;
    end else if (vector_ack) begin
      flag_reg <= 1'b0;
    end else if (sw_wr) begin
      flag_reg <= sw_val;
    end
  end

  a_edge_sets: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode && fall |=> flag)
    else $error("falling edge did not set flag");

  a_level_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    !edge_mode |=> flag == !$past(pin))
    else $error("level flag does not follow pin");

endmodule
`default_nettype wire

// ===== tb/pin_model.sv
// far-side model: external interrupt levels and count pin waveforms
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // clock
  input wire logic clk,
  // interrupt levels asked by the bench
  input wire logic [1:0] irq_level,
  // pins
  output logic ext_irq0_pin,
  output logic ext_irq1_pin,
  output logic count0_pin,
  output logic count1_pin
);
  // pins rest high so no stray falling edge shows at start
  logic [1:0] irq_reg = 2'h3;
  logic [1:0] phase_reg = 2'h0;

  // pins change only just after a clock edge, as a synchronous source
  always @(posedge clk) begin
    irq_reg <= irq_level;
    phase_reg <= phase_reg + 2'h1;
  end

  assign ext_irq0_pin = irq_reg[0];
  assign ext_irq1_pin = irq_reg[1];
  // free running: one fall per 2 clocks on pin 0, per 4 on pin 1
  assign count0_pin = ~phase_reg[0];
  assign count1_pin = ~phase_reg[1];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] mode, cks, run;
    logic [1:0] pins;
    logic [7:0] tl0, th0, tl1, th1, xl0, xh0, xl1, xh1;
    logic [1:0] xf;
  } case_s;
  logic sys_clk;
  logic reset_n;
  timer_pkg::sfr_req_s sfr_req;
  timer_pkg::bit_req_s bit_req;
  logic [7:0] sfr_rdata;
  logic bit_rdata;
  logic [3:0] acks;
  logic [1:0] irq_level;
  logic ext_irq0_pin, ext_irq1_pin, count0_pin, count1_pin;
  logic tf0, tf1, ie0, ie1;
  logic [1:0] flags;
  int error_cnt;
  int cmp_count;
  case_s cases [9];

  dual_timer_counter_control uut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .bit_req(bit_req), .bit_rdata(bit_rdata),
    .timer0_vector_ack(acks[0]), .timer1_vector_ack(acks[1]),
    .irq0_vector_ack(acks[2]), .irq1_vector_ack(acks[3]),
    .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
    .count0_pin(count0_pin), .count1_pin(count1_pin),
    .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1),
    .ext_irq0_detect_flag(ie0), .ext_irq1_detect_flag(ie1)
  );

  pin_model pins (
    .clk(sys_clk), .irq_level(irq_level),
    .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
    .count0_pin(count0_pin), .count1_pin(count1_pin)
  );

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    sfr_req <= '{wr: 1'b1, addr: addr, wdata: data};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
  endtask

  // read data is registered: look just after the edge that samples the address
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    sfr_req <= '{wr: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge sys_clk);
    #1;
    chk(name, exp, sfr_rdata);
  endtask

  task automatic bwr(input logic [7:0] addr, input logic val);
    @(posedge sys_clk);
    bit_req <= '{wr: 1'b1, addr: addr, val: val};
    @(posedge sys_clk);
    bit_req.wr <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] addr, input logic exp);
    @(posedge sys_clk);
    bit_req <= '{wr: 1'b0, addr: addr, val: 1'b0};
    @(posedge sys_clk);
    #1;
    chk("bit read", {7'h00, exp}, {7'h00, bit_rdata});
  endtask

  task automatic ack(input logic [3:0] which);
    @(posedge sys_clk);
    acks <= which;
    @(posedge sys_clk);
    acks <= 4'h0;
    #1;
  endtask

  task automatic irq_step(input logic [1:0] lvl, input logic [1:0] exp, input string name);
    @(posedge sys_clk);
    irq_level <= lvl;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(name, {6'h00, exp}, {6'h00, ie1, ie0});
  endtask

  // run window is exactly 48 counted edges, so tick phase never matters
  task automatic run_case(input case_s c);
    @(posedge sys_clk);
    irq_level <= c.pins;
    wr(timer_pkg::ADDR_MODE, c.mode);
    wr(timer_pkg::ADDR_CLK, c.cks);
    wr(timer_pkg::ADDR_T0L, c.tl0);
    wr(timer_pkg::ADDR_T0H, c.th0);
    wr(timer_pkg::ADDR_T1L, c.tl1);
    wr(timer_pkg::ADDR_T1H, c.th1);
    wr(timer_pkg::ADDR_CTRL, c.run);
    repeat (46) @(posedge sys_clk);
    #1;
    // flags sampled before the stop write, which clears them
    flags = {tf1, tf0};
    wr(timer_pkg::ADDR_CTRL, 8'h00);
    chk("overflow flags", {6'h00, c.xf}, {6'h00, flags});
    rd(timer_pkg::ADDR_T0L, c.xl0, "timer0 low");
    rd(timer_pkg::ADDR_T0H, c.xh0, "timer0 high");
    rd(timer_pkg::ADDR_T1L, c.xl1, "timer1 low");
    rd(timer_pkg::ADDR_T1H, c.xh1, "timer1 high");
    @(posedge sys_clk);
    irq_level <= 2'h3;
    $display("test mode %h clock %h run %h done", c.mode, c.cks, c.run);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    reset_n = 1'b0;
    sfr_req = '0;
    bit_req = '0;
    acks = 4'h0;
    irq_level = 2'h3;
    error_cnt = 0;
    cmp_count = 0;
    cases[0] = '{8'h00, 8'h10, 8'h50, 2'h3, 8'hFF, 8'h00, 8'h00, 8'h00,
                 8'hEB, 8'h01, 8'h04, 8'h00, 2'h0};
    cases[1] = '{8'h00, 8'h00, 8'h10, 2'h3, 8'hFF, 8'hFF, 8'h00, 8'h00,
                 8'hE3, 8'h00, 8'h00, 8'h00, 2'h1};
    cases[2] = '{8'h11, 8'h10, 8'h50, 2'h3, 8'hF8, 8'hFF, 8'hFE, 8'hFF,
                 8'h04, 8'h00, 8'h02, 8'h00, 2'h3};
    cases[3] = '{8'h22, 8'h30, 8'h50, 2'h3, 8'hFA, 8'hF0, 8'h00, 8'h80,
                 8'hF6, 8'hF0, 8'h0C, 8'h80, 2'h1};
    cases[4] = '{8'h33, 8'h10, 8'h50, 2'h3, 8'h10, 8'hFE, 8'h55, 8'h66,
                 8'h1C, 8'h0A, 8'h55, 8'h66, 2'h2};
    cases[5] = '{8'h11, 8'h30, 8'h00, 2'h3, 8'h12, 8'h34, 8'h56, 8'h78,
                 8'h12, 8'h34, 8'h56, 8'h78, 2'h0};
    cases[6] = '{8'h99, 8'h30, 8'h50, 2'h0, 8'hAA, 8'h00, 8'hBB, 8'h00,
                 8'hAA, 8'h00, 8'hBB, 8'h00, 2'h0};
    cases[7] = '{8'h99, 8'h30, 8'h50, 2'h3, 8'h00, 8'h00, 8'h00, 8'h00,
                 8'h0C, 8'h00, 8'h0C, 8'h00, 2'h0};
    cases[8] = '{8'h55, 8'h00, 8'h50, 2'h3, 8'h00, 8'h00, 8'h00, 8'h00,
                 8'h18, 8'h00, 8'h0C, 8'h00, 2'h0};
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);

    for (int a = 8'h88; a <= 8'h8E; a++) begin
      rd(a[7:0], (a == 8'h8E) ? ~timer_pkg::CLK_IMPL_MASK : 8'h00, "reset value");
    end
    rd(8'h80, 8'hFF, "unmapped");
    rd(8'h8F, 8'hFF, "unmapped");
    $display("test reset and unmapped reads done");

    foreach (cases[i]) begin
      run_case(cases[i]);
    end

    irq_step(2'h0, 2'h3, "level flags");
    ack(4'hC);
    chk("level after ack", 8'h03, {6'h00, ie1, ie0});
    irq_step(2'h3, 2'h0, "level release");
    wr(timer_pkg::ADDR_CTRL, 8'h05);
    irq_step(2'h0, 2'h3, "edge flags");
    irq_step(2'h3, 2'h3, "edge held");
    ack(4'h4);
    chk("edge ack irq0", 8'h02, {6'h00, ie1, ie0});
    ack(4'h8);
    chk("edge ack irq1", 8'h00, {6'h00, ie1, ie0});
    $display("test external interrupt detect done");

    bwr(8'h8F, 1'b1);
    bwr(8'h8D, 1'b1);
    rd(timer_pkg::ADDR_CTRL, 8'hA5, "control");
    brd(8'h8D, 1'b1);
    ack(4'h2);
    chk("timer1 ack", 8'h01, {6'h00, tf1, tf0});
    ack(4'h1);
    chk("timer0 ack", 8'h00, {6'h00, tf1, tf0});
    bwr(8'h90, 1'b1);
    brd(8'h90, 1'b1);
    rd(timer_pkg::ADDR_CTRL, 8'h05, "bit write outside");
    $display("test flag writes and vector clears done");
    wrap_up();
  end
endmodule
`default_nettype wire
